// ===== verilog/timer_irq_pkg.sv
// Shared constants and types for the prescaled timer and its interrupt unit
`default_nettype none
package timer_irq_pkg;
	localparam int CNT_W = 8; // Down-counter width
	localparam int PRE_W = 6; // Prescaler width
	localparam int NUM_IRQ = 6; // Interrupt sources
	localparam int ID_W = 3; // Source number width
	localparam int PC_W = 16; // Program address width
	localparam int NUM_PINS = 3; // Port-3 input lines
	localparam int SYNC_LEN = 3; // Synchroniser depth
	localparam logic [1:0] CPU_DIV_LAST = 2'h3; // Internal clock divided by four
	// Pin indices inside the synchroniser bank
	localparam int PIN_ONE = 0;
	localparam int PIN_TWO = 1;
	localparam int PIN_THREE = 2;
	// Request bit positions
	localparam int IRQ_TWO_FALL = 0;
	localparam int IRQ_THREE_FALL = 1;
	localparam int IRQ_ONE_FALL = 2;
	localparam int IRQ_TWO_RISE = 3;
	localparam int IRQ_SOFT = 4;
	localparam int IRQ_TIMER = 5;
	// Priority field positions
	localparam int PRIO_A_BIT = 5;
	localparam int PRIO_B_BIT = 2;
	localparam int PRIO_C_BIT = 1;
	localparam int PRIO_CODE_HI = 4;
	localparam int PRIO_CODE_MID = 3;
	localparam int PRIO_CODE_LO = 0;
	// Group order codes
	localparam logic [2:0] ORD_CAB = 3'h1;
	localparam logic [2:0] ORD_ABC = 3'h2;
	localparam logic [2:0] ORD_ACB = 3'h3;
	localparam logic [2:0] ORD_BCA = 3'h4;
	localparam logic [2:0] ORD_CBA = 3'h5;
	localparam logic [2:0] ORD_BAC = 3'h6;
	// Group selectors
	localparam logic [1:0] GRP_A = 2'h0;
	localparam logic [1:0] GRP_B = 2'h1;
	localparam logic [1:0] GRP_C = 2'h2;
	// Vector table layout
	localparam logic [15:0] VECTOR_BASE = 16'h0000;
	// Reset values
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [5:0] PRE_RST = 6'h00;
	localparam logic [5:0] REQ_RST = 6'h00;
	// External timer input use
	typedef enum logic [1:0] {
		EXT_CLOCK = 2'b00,
		EXT_TRIG_RETRIG = 2'b01,
		EXT_TRIG_ONCE = 2'b10,
		EXT_GATE = 2'b11
	} ext_mode_t;
	// Counter run state
	typedef enum logic [0:0] {
		RUN_IDLE = 1'b0,
		RUN_COUNT = 1'b1
	} run_state_t;
endpackage : timer_irq_pkg
`default_nettype wire

// ===== verilog/irq_link_if.sv
// Carrier between the timer top and the vectored interrupt unit
`default_nettype none
interface irq_link_if;
	logic [timer_irq_pkg::NUM_IRQ-1:0] reqSet; // Source event pulses
	logic [timer_irq_pkg::NUM_IRQ-1:0] reqClear; // Software clear pulses
	logic [timer_irq_pkg::NUM_IRQ-1:0] mask; // Per-source enables
	logic globalEn; // Global enable
	logic [5:0] prio; // Priority field
	logic irqCycle; // Interrupt machine cycle
	logic irqReenable; // Unblock after service
	logic [timer_irq_pkg::NUM_IRQ-1:0] pending; // Request flags
	logic irqToCore; // Request to core
	logic grantValid; // Grant pulse
	logic [timer_irq_pkg::ID_W-1:0] grantId; // Granted source
	logic [timer_irq_pkg::PC_W-1:0] vectorAddr; // Vector slot address
	logic blocked; // Further interrupts held off
	modport timer (output reqSet, reqClear, mask, globalEn, prio, irqCycle, irqReenable,
		input pending, irqToCore, grantValid, grantId, vectorAddr, blocked);
	modport unit (input reqSet, reqClear, mask, globalEn, prio, irqCycle, irqReenable,
		output pending, irqToCore, grantValid, grantId, vectorAddr, blocked);
endinterface : irq_link_if
`default_nettype wire

// ===== verilog/irq_vector_unit.sv
// Request flags, masking, priority encoder and vector grant
`default_nettype none
module irq_vector_unit (
	input wire logic mclk,
	input wire logic rstn,
	irq_link_if.unit link
);
	// Masked requests that may win
	logic [5:0] live;
	// Encoder result: valid bit and source number
	logic [3:0] pick;
	// Grant taken this cycle
	logic grantNow;

	// Winner of three groups in the programmed order
	function automatic logic [3:0] pickWinner(input logic [5:0] m, input logic [5:0] p);
		logic [2:0] gid [3];
		logic gok [3];
		logic [1:0] g1;
		logic [1:0] g2;
		logic [1:0] g3;
		gok[0] = m[3] | m[5];
		gid[0] = p[timer_irq_pkg::PRIO_A_BIT] ? (m[3] ? 3'h3 : 3'h5) : (m[5] ? 3'h5 : 3'h3);
		gok[1] = m[0] | m[2];
		gid[1] = p[timer_irq_pkg::PRIO_B_BIT] ? (m[0] ? 3'h0 : 3'h2) : (m[2] ? 3'h2 : 3'h0);
		gok[2] = m[1] | m[4];
		gid[2] = p[timer_irq_pkg::PRIO_C_BIT] ? (m[4] ? 3'h4 : 3'h1) : (m[1] ? 3'h1 : 3'h4);
		g1 = timer_irq_pkg::GRP_A;
		g2 = timer_irq_pkg::GRP_B;
		g3 = timer_irq_pkg::GRP_C;
		case ({p[timer_irq_pkg::PRIO_CODE_HI], p[timer_irq_pkg::PRIO_CODE_MID],
			p[timer_irq_pkg::PRIO_CODE_LO]})
			timer_irq_pkg::ORD_CAB: begin
				g1 = timer_irq_pkg::GRP_C; g2 = timer_irq_pkg::GRP_A; g3 = timer_irq_pkg::GRP_B;
			end
			timer_irq_pkg::ORD_ACB: begin
				g2 = timer_irq_pkg::GRP_C; g3 = timer_irq_pkg::GRP_B;
			end
			timer_irq_pkg::ORD_BCA: begin
				g1 = timer_irq_pkg::GRP_B; g2 = timer_irq_pkg::GRP_C; g3 = timer_irq_pkg::GRP_A;
			end
			timer_irq_pkg::ORD_CBA: begin
				g1 = timer_irq_pkg::GRP_C; g3 = timer_irq_pkg::GRP_A;
			end
			timer_irq_pkg::ORD_BAC: begin
				g1 = timer_irq_pkg::GRP_B; g2 = timer_irq_pkg::GRP_A;
			end
			// Order A, B, C; reserved codes fall here too
			default: begin
				g1 = timer_irq_pkg::GRP_A;
			end
		endcase
		if (gok[g1]) return {1'b1, gid[g1]};
		if (gok[g2]) return {1'b1, gid[g2]};
		if (gok[g3]) return {1'b1, gid[g3]};
		return 4'h0;
	endfunction : pickWinner

	// Mask and encode
	always_comb begin
		live = link.pending & link.mask & {6{link.globalEn}};
		pick = pickWinner(live, link.prio);
		grantNow = link.irqCycle & pick[3] & ~link.blocked;
	end

	assign link.irqToCore = pick[3] & ~link.blocked;

	// Request flags: set wins over clear and acknowledge
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			link.pending <= timer_irq_pkg::REQ_RST;
		end else begin
			link.pending <= (link.pending & ~link.reqClear
				& ~(grantNow ? (6'h01 << pick[2:0]) : 6'h00)) | link.reqSet;
		end
	end

	// Grant: block, announce, point at the vector slot
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			link.blocked <= 1'b0;
			link.grantValid <= 1'b0;
			link.grantId <= 3'h0;
			link.vectorAddr <= timer_irq_pkg::VECTOR_BASE;
		end else begin
			link.grantValid <= grantNow;
			if (grantNow) begin
				link.blocked <= 1'b1;
				link.grantId <= pick[2:0];
				link.vectorAddr <= timer_irq_pkg::VECTOR_BASE
					+ {12'h000, pick[2:0], 1'b0};
			end else if (link.irqReenable) begin
				link.blocked <= 1'b0;
			end
		end
	end
endmodule : irq_vector_unit
`default_nettype wire

// ===== verilog/prescaled_timer_irq.sv
// Prescaled 8-bit down-counter with six-source vectored interrupt unit
`default_nettype none
module prescaled_timer_irq #(
	parameter int CNT_W = timer_irq_pkg::CNT_W,
	parameter int PRE_W = timer_irq_pkg::PRE_W
) (
	input wire logic mclk,
	input wire logic rstn,
	// Port-3 pins, asynchronous
	input wire logic port3LineOne,
	input wire logic port3LineTwo,
	input wire logic port3LineThree,
	// Counter mode controls
	input wire logic counterModeExtSource,
	input wire logic [1:0] counterModeExtUse,
	input wire logic autoReloadCountMode,
	input wire logic [PRE_W-1:0] counterPrescalerReg,
	// Initial value write
	input wire logic [CNT_W-1:0] mainDownCounterLoad,
	input wire logic mainDownCounterWrite,
	// Run controls, one-cycle pulses
	input wire logic counterStart,
	input wire logic counterStop,
	input wire logic counterContinue,
	input wire logic counterReload,
	// Counter read-back and state
	output logic [CNT_W-1:0] mainDownCounter,
	output logic counterRunning,
	output logic counterIrqLine,
	// Interrupt controls
	input wire logic [5:0] irqMaskReg,
	input wire logic irqGlobalEnable,
	input wire logic [5:0] irqPriorityReg,
	input wire logic softwareRequest,
	input wire logic [5:0] irqRequestClear,
	input wire logic irqMachineCycle,
	input wire logic irqReturn,
	// Interrupt status and grant
	output logic [5:0] irqRequestReg,
	output logic irqToCore,
	output logic irqBlocked,
	output logic irqGrant,
	output logic [2:0] irqGrantSource,
	output logic [15:0] irqVectorAddr
);
	// Raw pins gathered for the synchroniser bank
	logic [timer_irq_pkg::NUM_PINS-1:0] pinRaw;
	// Three-stage synchroniser chains
	logic [timer_irq_pkg::SYNC_LEN-1:0] syncQ [timer_irq_pkg::NUM_PINS];
	// Filtered pin levels
	logic [timer_irq_pkg::NUM_PINS-1:0] levelQ;
	// Cycles since reset, stops once the chains hold real pin levels
	logic [2:0] flushQ;
	// Edge detection live
	logic flushed;
	// Edge pulses on filtered levels
	logic [timer_irq_pkg::NUM_PINS-1:0] riseEv;
	logic [timer_irq_pkg::NUM_PINS-1:0] fallEv;
	// Internal clock divider
	logic [1:0] cpuDivQ;
	// Initial value holding register
	logic [CNT_W-1:0] initQ;
	// Hidden prescaler count
	logic [PRE_W-1:0] preQ;
	// Live counter
	logic [CNT_W-1:0] cntQ;
	// Run state
	timer_irq_pkg::run_state_t runQ;
	// Trigger has fired and counting is live
	logic trigActiveQ;
	// Timer request pulse register
	logic counterIrqQ;
	// External use decoded
	timer_irq_pkg::ext_mode_t extUse;
	// Tick sources and qualifiers
	logic intTick;
	logic srcTick;
	logic gateOpen;
	logic trigEdge;
	logic needTrig;
	logic counting;
	logic preTick;
	logic preOut;
	logic endOfCount;
	logic loadNow;
	logic [PRE_W-1:0] preTop;

	// Link to the interrupt unit
	irq_link_if link ();

	assign pinRaw = {port3LineThree, port3LineTwo, port3LineOne};
	assign extUse = timer_irq_pkg::ext_mode_t'(counterModeExtUse);

	// Flush counter: held levels start from reset, not from the pins,
	// so an edge seen before the chains have filled would be false
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			flushQ <= 3'h0;
		end else if (!flushed) begin
			flushQ <= flushQ + 3'h1;
		end
	end

	assign flushed = (flushQ == 3'(timer_irq_pkg::SYNC_LEN + 1));

	// Synchroniser and edge filter for each pin
	genvar gi;
	generate
		for (gi = 0; gi < timer_irq_pkg::NUM_PINS; gi++) begin : gPin
			// Shift chain; stage 0 is read only by stage 1
			always_ff @(posedge mclk) begin
				if (!rstn) begin
					syncQ[gi] <= '0;
				end else begin
					syncQ[gi] <= {syncQ[gi][timer_irq_pkg::SYNC_LEN-2:0], pinRaw[gi]};
				end
			end
			// Level accepted once the last two stages agree
			always_ff @(posedge mclk) begin
				if (!rstn) begin
					levelQ[gi] <= 1'b0;
				end else if (syncQ[gi][1] == syncQ[gi][2]) begin
					levelQ[gi] <= syncQ[gi][1];
				end
			end
			// Edges on agreement that differs from the held level, once flushed
			assign riseEv[gi] = flushed & (syncQ[gi][1] == syncQ[gi][2])
				& syncQ[gi][1] & ~levelQ[gi];
			assign fallEv[gi] = flushed & (syncQ[gi][1] == syncQ[gi][2])
				& ~syncQ[gi][1] & levelQ[gi];
		end
	endgenerate

	// Internal clock divided by four
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cpuDivQ <= 2'h0;
		end else begin
			cpuDivQ <= cpuDivQ + 2'h1;
		end
	end

	assign intTick = (cpuDivQ == timer_irq_pkg::CPU_DIV_LAST);

	// Source selection and external input use
	always_comb begin
		srcTick = intTick;
		gateOpen = 1'b1;
		trigEdge = 1'b0;
		needTrig = 1'b0;
		if (counterModeExtSource) begin
			unique case (extUse)
				// Falling edges of the timer input are the clock
				timer_irq_pkg::EXT_CLOCK: begin
					srcTick = fallEv[timer_irq_pkg::PIN_ONE];
				end
				// A falling edge while the counter runs restarts the count
				timer_irq_pkg::EXT_TRIG_RETRIG: begin
					needTrig = 1'b1;
					trigEdge = fallEv[timer_irq_pkg::PIN_ONE];
				end
				// Edges ignored while a count is live
				timer_irq_pkg::EXT_TRIG_ONCE: begin
					needTrig = 1'b1;
					trigEdge = fallEv[timer_irq_pkg::PIN_ONE] & ~trigActiveQ;
				end
				// High level lets the internal clock through
				timer_irq_pkg::EXT_GATE: begin
					gateOpen = levelQ[timer_irq_pkg::PIN_ONE];
				end
			endcase
		end
	end

	// Counting qualifiers and terminal detection
	always_comb begin
		preTop = counterPrescalerReg - 6'h01; // Zero ratio wraps to 64
		counting = (runQ == timer_irq_pkg::RUN_COUNT) & gateOpen & (~needTrig | trigActiveQ);
		preTick = counting & srcTick;
		preOut = preTick & (preQ == preTop);
		endOfCount = preOut & (cntQ == 8'h01);
		loadNow = counterStart | counterReload
			| (trigEdge & (runQ == timer_irq_pkg::RUN_COUNT));
	end

	// Initial value written by software
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			initQ <= timer_irq_pkg::CNT_RST;
		end else if (mainDownCounterWrite) begin
			initQ <= mainDownCounterLoad;
		end
	end

	// Run state: stop beats start, single pass ends the run outside trigger modes
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			runQ <= timer_irq_pkg::RUN_IDLE;
		end else if (counterStop) begin
			runQ <= timer_irq_pkg::RUN_IDLE;
		end else if (counterStart | counterContinue) begin
			runQ <= timer_irq_pkg::RUN_COUNT;
		end else if (endOfCount & ~autoReloadCountMode & ~needTrig) begin
			runQ <= timer_irq_pkg::RUN_IDLE;
		end
	end

	// Trigger state; trigger modes stay armed after a single pass
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			trigActiveQ <= 1'b0;
		end else if (counterStop | counterStart) begin
			trigActiveQ <= 1'b0;
		end else if (trigEdge & (runQ == timer_irq_pkg::RUN_COUNT)) begin
			trigActiveQ <= 1'b1;
		end else if (endOfCount & ~autoReloadCountMode) begin
			trigActiveQ <= 1'b0;
		end
	end

	// Hidden prescaler, cleared on every load
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			preQ <= timer_irq_pkg::PRE_RST;
		end else if (loadNow) begin
			preQ <= timer_irq_pkg::PRE_RST;
		end else if (preTick) begin
			preQ <= preOut ? timer_irq_pkg::PRE_RST : preQ + 6'h01;
		end
	end

	// Down-counter; a loaded zero counts 256
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cntQ <= timer_irq_pkg::CNT_RST;
		end else if (loadNow) begin
			cntQ <= initQ;
		end else if (endOfCount) begin
			cntQ <= autoReloadCountMode ? initQ : 8'h00;
		end else if (preOut) begin
			cntQ <= cntQ - 8'h01;
		end
	end

	// Timer request pulse, one cycle after end of count
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			counterIrqQ <= 1'b0;
		end else begin
			counterIrqQ <= endOfCount;
		end
	end

	// Reads see the live count with no side effect
	assign mainDownCounter = cntQ;
	assign counterRunning = (runQ == timer_irq_pkg::RUN_COUNT);
	assign counterIrqLine = counterIrqQ;

	// Source events into the request flags
	always_comb begin
		link.reqSet = 6'h00;
		link.reqSet[timer_irq_pkg::IRQ_TWO_FALL] = fallEv[timer_irq_pkg::PIN_TWO];
		link.reqSet[timer_irq_pkg::IRQ_THREE_FALL] = fallEv[timer_irq_pkg::PIN_THREE];
		link.reqSet[timer_irq_pkg::IRQ_ONE_FALL] = fallEv[timer_irq_pkg::PIN_ONE];
		link.reqSet[timer_irq_pkg::IRQ_TWO_RISE] = riseEv[timer_irq_pkg::PIN_TWO];
		link.reqSet[timer_irq_pkg::IRQ_SOFT] = softwareRequest;
		link.reqSet[timer_irq_pkg::IRQ_TIMER] = counterIrqQ;
	end

	// Controls passed through to the interrupt unit
	assign link.reqClear = irqRequestClear;
	assign link.mask = irqMaskReg;
	assign link.globalEn = irqGlobalEnable;
	assign link.prio = irqPriorityReg;
	assign link.irqCycle = irqMachineCycle;
	assign link.irqReenable = irqReturn;

	// Vectored interrupt unit
	irq_vector_unit uIrq (
		.mclk(mclk),
		.rstn(rstn),
		.link(link)
	);

	// Status and grant outputs; flags readable for polled use
	assign irqRequestReg = link.pending;
	assign irqToCore = link.irqToCore;
	assign irqBlocked = link.blocked;
	assign irqGrant = link.grantValid;
	assign irqGrantSource = link.grantId;
	assign irqVectorAddr = link.vectorAddr;
endmodule : prescaled_timer_irq
`default_nettype wire

// ===== testbench/timer_irq_sva.sv
// Concurrent checks on the timer and interrupt unit ports
`default_nettype none
module timer_irq_sva #(
	parameter int CNT_W = 8
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic counterStart,
	input wire logic counterStop,
	input wire logic counterContinue,
	input wire logic counterReload,
	input wire logic mainDownCounterWrite,
	input wire logic autoReloadCountMode,
	input wire logic counterModeExtSource,
	input wire logic [CNT_W-1:0] mainDownCounter,
	input wire logic counterRunning,
	input wire logic counterIrqLine,
	input wire logic [5:0] irqMaskReg,
	input wire logic irqGlobalEnable,
	input wire logic softwareRequest,
	input wire logic irqMachineCycle,
	input wire logic irqReturn,
	input wire logic [5:0] irqRequestReg,
	input wire logic irqToCore,
	input wire logic irqBlocked,
	input wire logic irqGrant,
	input wire logic [2:0] irqGrantSource,
	input wire logic [15:0] irqVectorAddr
);
	timeunit 1ns;
	timeprecision 100ps;
	// One clock domain, reset gates every check
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	property p_toCore;
		irqToCore == (irqGlobalEnable && !irqBlocked && |(irqRequestReg & irqMaskReg));
	endproperty
	a_toCore: assert property (p_toCore) else $error("core request mismatch");
	property p_ack;
		irqMachineCycle && irqToCore |=> irqGrant && irqBlocked;
	endproperty
	a_ack: assert property (p_ack) else $error("machine cycle not granted");
	property p_grantCause;
		irqGrant |-> $past(irqMachineCycle);
	endproperty
	a_grantCause: assert property (p_grantCause) else $error("grant without cycle");
	property p_vector;
		irqGrant |-> irqVectorAddr == {12'h000, irqGrantSource, 1'b0} && irqGrantSource < 3'h6;
	endproperty
	a_vector: assert property (p_vector) else $error("bad vector slot");
	property p_blockHold;
		irqBlocked && !irqReturn |=> irqBlocked;
	endproperty
	a_blockHold: assert property (p_blockHold) else $error("block dropped early");
	property p_unblock;
		irqBlocked && irqReturn |=> !irqBlocked;
	endproperty
	a_unblock: assert property (p_unblock) else $error("block not released");
	property p_swReq;
		softwareRequest |=> irqRequestReg[4];
	endproperty
	a_swReq: assert property (p_swReq) else $error("software flag not set");
	property p_timerReq;
		counterIrqLine |-> ##[0:1] irqRequestReg[5];
	endproperty
	a_timerReq: assert property (p_timerReq) else $error("timer flag not set");
	property p_pulse;
		counterIrqLine |=> !counterIrqLine;
	endproperty
	a_pulse: assert property (p_pulse) else $error("end pulse too long");
	property p_single;
		counterIrqLine && !autoReloadCountMode && !counterModeExtSource
			|-> mainDownCounter == '0 && !counterRunning;
	endproperty
	a_single: assert property (p_single) else $error("single pass not halted");
	property p_hold;
		!counterRunning && !counterStart && !counterContinue && !counterReload
			&& !mainDownCounterWrite |=> $stable(mainDownCounter);
	endproperty
	a_hold: assert property (p_hold) else $error("idle count moved");
	property p_stop;
		counterStop |=> !counterRunning;
	endproperty
	a_stop: assert property (p_stop) else $error("stop ignored");
	// Main scenarios reached
	c_grant: cover property (irqGrant);
	c_timerEnd: cover property (counterIrqLine && autoReloadCountMode);
	c_unblock: cover property (irqBlocked && irqReturn);
endmodule : timer_irq_sva
bind prescaled_timer_irq timer_irq_sva #(.CNT_W(CNT_W)) i_sva (.mclk, .rstn, .counterStart,
	.counterStop, .counterContinue, .counterReload, .mainDownCounterWrite, .autoReloadCountMode,
	.counterModeExtSource, .mainDownCounter, .counterRunning, .counterIrqLine, .irqMaskReg,
	.irqGlobalEnable, .softwareRequest, .irqMachineCycle, .irqReturn, .irqRequestReg,
	.irqToCore, .irqBlocked, .irqGrant, .irqGrantSource, .irqVectorAddr);
`default_nettype wire

// ===== testbench/core_ack_model.sv
// Core-side model: takes interrupt grants and returns from service
`default_nettype none
module core_ack_model (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ackEn,
	input wire logic irqToCore,
	input wire logic irqGrant,
	output logic irqMachineCycle,
	output logic irqReturn
);
	timeunit 1ns;
	timeprecision 100ps;
	logic busy_q; // Service in progress
	logic [1:0] wait_q; // Service length left
	// Machine cycle on request, return four cycles after grant
	always_ff @(posedge mclk) begin
		irqMachineCycle <= 1'b0;
		irqReturn <= 1'b0;
		if (!rstn || !ackEn) begin
			busy_q <= 1'b0;
			wait_q <= 2'h0;
		end else if (irqToCore && !busy_q) begin
			irqMachineCycle <= 1'b1;
			busy_q <= 1'b1;
		end else if (irqGrant) begin
			wait_q <= 2'h3;
		end else if (wait_q != 2'h0) begin
			wait_q <= wait_q - 2'h1;
			// Last service cycle: unblock
			if (wait_q == 2'h1) begin
				irqReturn <= 1'b1;
				busy_q <= 1'b0;
			end
		end
	end
endmodule : core_ack_model
`default_nettype wire

// ===== testbench/prescaled_timer_irq_tb.sv
// Self-checking bench for the prescaled timer and interrupt unit
`default_nettype none
module prescaled_timer_irq_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic port3LineOne = 1'b1, port3LineTwo = 1'b1, port3LineThree = 1'b1; // Pins idle high
	logic counterModeExtSource = 1'b0, autoReloadCountMode = 1'b0;
	logic [1:0] counterModeExtUse = 2'h0;
	logic [5:0] counterPrescalerReg = 6'h01;
	logic [7:0] mainDownCounterLoad = 8'h00;
	logic mainDownCounterWrite = 1'b0, counterStart = 1'b0, counterStop = 1'b0;
	logic counterContinue = 1'b0, counterReload = 1'b0, softwareRequest = 1'b0;
	logic [5:0] irqMaskReg = 6'h00, irqPriorityReg = 6'h08, irqRequestClear = 6'h00;
	logic irqGlobalEnable = 1'b0, ackEn = 1'b0, irqMachineCycle, irqReturn;
	logic [7:0] mainDownCounter;
	logic counterRunning, counterIrqLine, irqToCore, irqBlocked, irqGrant;
	logic [5:0] irqRequestReg;
	logic [2:0] irqGrantSource;
	logic [15:0] irqVectorAddr;
	int n_errors = 0, compares = 0, cycles = 0;
	// Grant orders for six priority settings, one per group order
	logic [2:0] order [6][5] = '{'{3'h3, 3'h2, 3'h0, 3'h1, 3'h4}, '{3'h4, 3'h1, 3'h0, 3'h2, 3'h3},
		'{3'h1, 3'h4, 3'h3, 3'h2, 3'h0}, '{3'h3, 3'h1, 3'h4, 3'h0, 3'h2},
		'{3'h2, 3'h0, 3'h4, 3'h1, 3'h3}, '{3'h0, 3'h2, 3'h3, 3'h4, 3'h1}};
	logic [5:0] prio [6] = '{6'h08, 6'h37, 6'h01, 6'h0d, 6'h12, 6'h1e};
	prescaled_timer_irq i_dut (.mclk, .rstn, .port3LineOne, .port3LineTwo, .port3LineThree,
		.counterModeExtSource, .counterModeExtUse, .autoReloadCountMode, .counterPrescalerReg,
		.mainDownCounterLoad, .mainDownCounterWrite, .counterStart, .counterStop,
		.counterContinue, .counterReload, .mainDownCounter, .counterRunning, .counterIrqLine,
		.irqMaskReg, .irqGlobalEnable, .irqPriorityReg, .softwareRequest, .irqRequestClear,
		.irqMachineCycle, .irqReturn, .irqRequestReg, .irqToCore, .irqBlocked, .irqGrant,
		.irqGrantSource, .irqVectorAddr);
	core_ack_model i_core (.mclk, .rstn, .ackEn, .irqToCore, .irqGrant, .irqMachineCycle,
		.irqReturn);
	// Clock and hang guard
	always #2 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// Steps just past the clock edge
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse
	task automatic pin(ref logic p, input logic v);
		p = v;
		tick(6);
	endtask : pin
	task automatic waitFor(ref logic s, output int n);
		n = 0;
		while (s !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
		if (n == 3000) cmp(16'h1, 16'h0);
	endtask : waitFor
	task automatic arm(input logic [7:0] ld, input logic [5:0] ratio);
		counterPrescalerReg = ratio;
		mainDownCounterLoad = ld;
		pulse(mainDownCounterWrite);
		pulse(counterStart);
	endtask : arm
	task automatic t_single();
		int n;
		arm(8'h03, 6'h02);
		cmp(16'(mainDownCounter), 16'h3);
		waitFor(counterIrqLine, n);
		cmp(16'(n >= 18 && n <= 26), 16'h1);
		cmp({counterRunning, mainDownCounter}, 16'h0);
		tick(1);
		cmp(16'(irqRequestReg[5]), 16'h1);
	endtask : t_single
	task automatic t_cont();
		int n;
		logic [7:0] ld [3] = '{8'h02, 8'h01, 8'h00};
		logic [5:0] ra [3] = '{6'h03, 6'h00, 6'h01};
		int per [3] = '{24, 256, 1024};
		autoReloadCountMode = 1'b1;
		for (int i = 0; i < 3; i++) begin
			arm(ld[i], ra[i]);
			waitFor(counterIrqLine, n);
			cmp(16'(mainDownCounter), 16'(ld[i]));
			tick(1);
			waitFor(counterIrqLine, n);
			cmp(16'(n + 1), 16'(per[i]));
			pulse(counterStop);
		end
		autoReloadCountMode = 1'b0;
	endtask : t_cont
	task automatic t_stopGo();
		logic [7:0] v;
		arm(8'h40, 6'h01);
		tick(20);
		pulse(counterStop);
		v = mainDownCounter;
		tick(30);
		cmp(16'(mainDownCounter), 16'(v));
		cmp(16'(v < 8'h40 && !counterRunning), 16'h1);
		pulse(counterContinue);
		tick(40);
		cmp(16'(mainDownCounter < v && counterRunning), 16'h1);
		pulse(counterReload);
		cmp(16'(mainDownCounter), 16'h40);
		pulse(counterStop);
	endtask : t_stopGo
	task automatic t_external();
		int n;
		counterModeExtSource = 1'b1;
		arm(8'h02, 6'h01);
		pin(port3LineOne, 1'b0);
		pin(port3LineOne, 1'b1);
		port3LineOne = 1'b0;
		waitFor(counterIrqLine, n);
		cmp(16'(n < 10), 16'h1);
		counterModeExtUse = 2'h3;
		arm(8'h01, 6'h01);
		tick(40);
		cmp(16'(mainDownCounter), 16'h1);
		port3LineOne = 1'b1;
		waitFor(counterIrqLine, n);
		cmp(16'(n < 12), 16'h1);
		for (int u = 1; u < 3; u++) begin
			counterModeExtUse = 2'(u);
			arm(8'h01, 6'h01);
			tick(20);
			port3LineOne = 1'b0;
			waitFor(counterIrqLine, n);
			cmp(16'(n >= 3 && n < 14), 16'h1);
			pin(port3LineOne, 1'b1);
			pulse(counterStop);
		end
		counterModeExtSource = 1'b0;
	endtask : t_external
	task automatic t_vectors();
		int n;
		irqGlobalEnable = 1'b1;
		for (int p = 0; p < 6; p++) begin
			irqRequestClear = 6'h3f;
			tick(1);
			irqRequestClear = 6'h00;
			irqMaskReg = 6'h00;
			pin(port3LineTwo, 1'b0);
			pin(port3LineTwo, 1'b1);
			pin(port3LineThree, 1'b0);
			pin(port3LineOne, 1'b0);
			pulse(softwareRequest);
			pin(port3LineThree, 1'b1);
			pin(port3LineOne, 1'b1);
			cmp(16'(irqRequestReg), 16'h1f);
			cmp(16'(irqToCore), 16'h0);
			irqMaskReg = 6'h3f;
			irqGlobalEnable = 1'b0;
			tick(1);
			cmp(16'(irqToCore), 16'h0);
			irqGlobalEnable = 1'b1;
			irqPriorityReg = prio[p];
			ackEn = 1'b1;
			for (int k = 0; k < 5; k++) begin
				waitFor(irqGrant, n);
				cmp(16'(irqGrantSource), 16'(order[p][k]));
				cmp(irqVectorAddr, 16'(2 * order[p][k]));
				cmp(16'(irqBlocked), 16'h1);
				tick(1);
			end
			tick(6);
			cmp(16'(irqRequestReg), 16'h00);
			ackEn = 1'b0;
		end
	endtask : t_vectors
	// Main sequence
	initial begin
		tick(2);
		rstn = 1'b1;
		cmp({irqRequestReg, irqBlocked, counterRunning, mainDownCounter}, 16'h0);
		tick(4);
		cmp(16'(irqRequestReg), 16'h00);
		t_single();
		t_cont();
		t_stopGo();
		t_external();
		t_vectors();
		finish_test();
	end
endmodule : prescaled_timer_irq_tb
`default_nettype wire
